// >>> hw/sef_consts.svh
// Register offsets, field positions, reset values and counts of the receive-error block.
`ifndef SEF_CONSTS_SVH
`define SEF_CONSTS_SVH

`define SEF_OFS_STATUS   8'h00
`define SEF_OFS_HOLD     8'h04
`define SEF_OFS_CTRL     8'h08
`define SEF_OFS_IRQ_STAT 8'h0c
`define SEF_OFS_IRQ_MASK 8'h10

`define SEF_BIT_RXF      6
`define SEF_BIT_OVR      5
`define SEF_BIT_FRM      4

`define SEF_CTL_RXEN     0
`define SEF_CTL_TWOSTOP  1
`define SEF_CTL_SYNC     2
`define SEF_CTL_DIV_LO   8
`define SEF_CTL_DIV_HI   15

`define SEF_IRQ_RXDONE   0
`define SEF_IRQ_OVR      1
`define SEF_IRQ_FRM      2
`define SEF_IRQ_W        3

`define SEF_DIV_RST      8'h00
`define SEF_OVS_MID      4'h7
`define SEF_OVS_LAST     4'hf
`define SEF_LAST_BIT     3'h7

`define SEF_RESP_OKAY    2'h0
`define SEF_RESP_SLVERR  2'h2

`endif

// >>> hw/sef_pkg.sv
// Types shared by the receive-error block and its receiver.
package sef_pkg;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } sef_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sef_axi_rsp_t;

    typedef struct packed {
        logic       done;
        logic       stop_err;
        logic [7:0] data;
    } sef_rx_evt_t;

    typedef enum logic [2:0] {
        SEF_RX_IDLE  = 3'b000,
        SEF_RX_START = 3'b001,
        SEF_RX_DATA  = 3'b010,
        SEF_RX_STOP1 = 3'b011,
        SEF_RX_STOP2 = 3'b100
    } sef_rx_state_t;

    typedef struct packed {
        logic          pin_meta;
        logic          pin_sync;
        sef_rx_state_t st;
        logic [3:0]    cnt;
        logic [2:0]    idx;
        logic [7:0]    shift;
        sef_rx_evt_t   evt;
    } sef_rx_regs_t;

    typedef struct packed {
        sef_axi_rsp_t          rsp;
        logic                  have_aw;
        logic                  have_w;
        logic [7:0]            waddr;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  rx_full;
        logic                  overrun;
        logic                  framing;
        logic                  rxf_seen;
        logic                  ovr_seen;
        logic                  frm_seen;
        logic [7:0]            hold;
        logic                  rx_en;
        logic                  two_stop;
        logic                  sync_mode;
        logic [7:0]            divisor;
        logic [7:0]            div_cnt;
        logic                  tick;
        logic [2:0]            irq_stat;
        logic [2:0]            irq_mask;
        logic                  irq;
        logic                  tx_halt;
    } sef_regs_t;

endpackage

// >>> hw/sef_rx_frame.sv
// Oversampling character receiver that reports each finished frame and its first stop bit.
`include "sef_consts.svh"
module sef_rx_frame
    import sef_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        rxd,
    input  wire logic        enable,
    input  wire logic        tick,
    input  wire logic        two_stop,
    input  wire logic        check_stop,
    output sef_rx_evt_t      evt
);

    sef_rx_regs_t q;
    sef_rx_regs_t d;

    always_comb begin
        d          = q;
        d.pin_meta = rxd;
        d.pin_sync = q.pin_meta;
        d.evt.done = 1'b0;
        if (!enable) begin
            // Leaving a frame half-read is safer than finishing it while an error is pending.
            d.st  = SEF_RX_IDLE;
            d.cnt = 4'h0;
        end else if (tick) begin
            d.cnt = q.cnt + 4'h1;
            case (q.st)
                SEF_RX_IDLE: begin
                    d.cnt = 4'h0;
                    if (!q.pin_sync) begin
                        d.st = SEF_RX_START;
                    end
                end
                SEF_RX_START: begin
                    if (q.cnt == `SEF_OVS_MID) begin
                        d.cnt = 4'h0;
                        d.idx = 3'h0;
                        d.st  = q.pin_sync ? SEF_RX_IDLE : SEF_RX_DATA;
                    end
                end
                SEF_RX_DATA: begin
                    if (q.cnt == `SEF_OVS_LAST) begin
                        d.shift = {q.pin_sync, q.shift[7:1]};
                        d.idx   = q.idx + 3'h1;
                        if (q.idx == `SEF_LAST_BIT) begin
                            d.st = SEF_RX_STOP1;
                        end
                    end
                end
                SEF_RX_STOP1: begin
                    if (q.cnt == `SEF_OVS_LAST) begin
                        d.evt.stop_err = check_stop && !q.pin_sync;
                        d.evt.data     = q.shift;
                        if (two_stop) begin
                            d.st = SEF_RX_STOP2;
                        end else begin
                            d.st       = SEF_RX_IDLE;
                            d.evt.done = 1'b1;
                        end
                    end
                end
                SEF_RX_STOP2: begin
                    if (q.cnt == `SEF_OVS_LAST) begin
                        d.st       = SEF_RX_IDLE;
                        d.evt.done = 1'b1;
                    end
                end
                default: begin
                    d.st = SEF_RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q          <= '0;
            q.pin_meta <= 1'b1;
            q.pin_sync <= 1'b1;
            q.st       <= SEF_RX_IDLE;
        end else begin
            q <= d;
        end
    end

    assign evt = q.evt;

endmodule

// >>> hw/sef_top.sv
// Serial receive-error flags with holding register, AXI4-Lite registers and interrupt.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`include "sef_consts.svh"
module sef_top
    import sef_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  sef_axi_req_t     axi_req,
    output sef_axi_rsp_t     axi_rsp,
    input  wire logic        rxd,
    output logic             irq,
    output logic             tx_halt
);

    sef_regs_t   q;
    sef_regs_t   d;
    sef_rx_evt_t evt;
    logic        error_hold;

    assign error_hold = q.overrun || q.framing;

    sef_rx_frame u_rx (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .rxd        (rxd),
        .enable     (q.rx_en && !error_hold),
        .tick       (q.tick),
        .two_stop   (q.two_stop),
        .check_stop (!q.sync_mode),
        .evt        (evt)
    );

    always_comb begin
        logic        aw_hs;
        logic        w_hs;
        logic        ar_hs;
        logic        do_wr;
        logic        wr_lane0;
        logic [7:0]  raddr;
        logic [7:0]  status;
        logic [2:0]  ev;
        aw_hs    = axi_req.awvalid && q.rsp.awready;
        w_hs     = axi_req.wvalid && q.rsp.wready;
        ar_hs    = axi_req.arvalid && q.rsp.arready;
        do_wr    = q.have_aw && q.have_w && !q.rsp.bvalid;
        wr_lane0 = do_wr && q.wstrb[0];
        raddr    = axi_req.araddr[7:0];
        status   = 8'h00;
        status[`SEF_BIT_RXF] = q.rx_full;
        status[`SEF_BIT_OVR] = q.overrun;
        status[`SEF_BIT_FRM] = q.framing;
        ev       = 3'h0;
        d        = q;

        // The divider gives a one-cycle oversampling enable every divisor+1 clocks.
        d.tick = 1'b0;
        if (q.div_cnt == 8'h00) begin
            d.div_cnt = q.divisor;
            d.tick    = 1'b1;
        end else begin
            d.div_cnt = q.div_cnt - 8'h01;
        end

        // Write channel capture; address and data may arrive in either order.
        if (aw_hs) begin
            d.have_aw = 1'b1;
            d.waddr   = axi_req.awaddr[7:0];
        end
        if (w_hs) begin
            d.have_w = 1'b1;
            d.wdata  = axi_req.wdata;
            d.wstrb  = axi_req.wstrb;
        end
        if (q.rsp.bvalid && axi_req.bready) begin
            d.rsp.bvalid = 1'b0;
        end
        if (do_wr) begin
            d.have_aw      = 1'b0;
            d.have_w       = 1'b0;
            d.rsp.bvalid   = 1'b1;
            d.rsp.bresp    = `SEF_RESP_OKAY;
            case (q.waddr)
                `SEF_OFS_STATUS: begin
                    // A one written to a flag bit is simply ignored.
                    if (wr_lane0 && !q.wdata[`SEF_BIT_RXF] && q.rxf_seen) begin
                        d.rx_full  = 1'b0;
                        d.rxf_seen = 1'b0;
                    end
                    if (wr_lane0 && !q.wdata[`SEF_BIT_OVR] && q.ovr_seen) begin
                        d.overrun  = 1'b0;
                        d.ovr_seen = 1'b0;
                    end
                    if (wr_lane0 && !q.wdata[`SEF_BIT_FRM] && q.frm_seen) begin
                        d.framing  = 1'b0;
                        d.frm_seen = 1'b0;
                    end
                end
                `SEF_OFS_HOLD: begin
                end
                `SEF_OFS_CTRL: begin
                    // Control bits only; the error flags live elsewhere and stay put.
                    if (q.wstrb[0]) begin
                        d.rx_en     = q.wdata[`SEF_CTL_RXEN];
                        d.two_stop  = q.wdata[`SEF_CTL_TWOSTOP];
                        d.sync_mode = q.wdata[`SEF_CTL_SYNC];
                    end
                    if (q.wstrb[1]) begin
                        d.divisor = q.wdata[`SEF_CTL_DIV_HI:`SEF_CTL_DIV_LO];
                    end
                end
                `SEF_OFS_IRQ_STAT: begin
                    if (q.wstrb[0]) begin
                        d.irq_stat = q.irq_stat & ~q.wdata[`SEF_IRQ_W-1:0];
                    end
                end
                `SEF_OFS_IRQ_MASK: begin
                    if (q.wstrb[0]) begin
                        d.irq_mask = q.wdata[`SEF_IRQ_W-1:0];
                    end
                end
                default: begin
                    d.rsp.bresp = `SEF_RESP_SLVERR;
                end
            endcase
        end
        d.rsp.awready = !d.have_aw && !d.rsp.bvalid;
        d.rsp.wready  = !d.have_w && !d.rsp.bvalid;

        // Read channel; reading the status arms the clear of each flag seen at one.
        if (q.rsp.rvalid && axi_req.rready) begin
            d.rsp.rvalid = 1'b0;
        end
        if (ar_hs) begin
            d.rsp.rvalid = 1'b1;
            d.rsp.rresp  = `SEF_RESP_OKAY;
            d.rsp.rdata  = 32'h0000_0000;
            case (raddr)
                `SEF_OFS_STATUS: begin
                    d.rsp.rdata[7:0] = status;
                    d.rxf_seen = q.rxf_seen || q.rx_full;
                    d.ovr_seen = q.ovr_seen || q.overrun;
                    d.frm_seen = q.frm_seen || q.framing;
                end
                `SEF_OFS_HOLD: begin
                    d.rsp.rdata[7:0] = q.hold;
                end
                `SEF_OFS_CTRL: begin
                    d.rsp.rdata[`SEF_CTL_RXEN]    = q.rx_en;
                    d.rsp.rdata[`SEF_CTL_TWOSTOP] = q.two_stop;
                    d.rsp.rdata[`SEF_CTL_SYNC]    = q.sync_mode;
                    d.rsp.rdata[`SEF_CTL_DIV_HI:`SEF_CTL_DIV_LO] = q.divisor;
                end
                `SEF_OFS_IRQ_STAT: begin
                    d.rsp.rdata[`SEF_IRQ_W-1:0] = q.irq_stat;
                end
                `SEF_OFS_IRQ_MASK: begin
                    d.rsp.rdata[`SEF_IRQ_W-1:0] = q.irq_mask;
                end
                default: begin
                    d.rsp.rresp = `SEF_RESP_SLVERR;
                end
            endcase
        end
        d.rsp.arready = !d.rsp.rvalid;

        // Frame completion is applied last so that a set beats a clear in the same cycle.
        if (evt.done) begin
            if (q.rx_full) begin
                d.overrun = 1'b1;
                ev[`SEF_IRQ_OVR] = 1'b1;
            end else if (evt.stop_err) begin
                d.hold    = evt.data;
                d.framing = 1'b1;
                ev[`SEF_IRQ_FRM] = 1'b1;
            end else begin
                d.hold    = evt.data;
                d.rx_full = 1'b1;
                ev[`SEF_IRQ_RXDONE] = 1'b1;
            end
        end
        // A flag set again while armed must be read again before it can be cleared.
        if (ev[`SEF_IRQ_OVR]) begin
            d.ovr_seen = 1'b0;
        end
        if (ev[`SEF_IRQ_FRM]) begin
            d.frm_seen = 1'b0;
        end
        if (ev[`SEF_IRQ_RXDONE]) begin
            d.rxf_seen = 1'b0;
        end
        d.irq_stat = d.irq_stat | ev;
        d.irq      = |(d.irq_stat & d.irq_mask);
        d.tx_halt  = d.sync_mode && (d.overrun || d.framing);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q         <= '0;
            q.divisor <= `SEF_DIV_RST;
            q.div_cnt <= `SEF_DIV_RST;
        end else begin
            q <= d;
        end
    end

    assign axi_rsp = q.rsp;
    assign irq     = q.irq;
    assign tx_halt = q.tx_halt;

endmodule

// >>> verification/sef_top_monitor.sv
// Port-level checker for the receive-error block.
module sef_top_monitor
    import sef_pkg::*;
(
    input wire logic    aclk,
    input wire logic    aresetn,
    input sef_axi_req_t axi_req,
    input sef_axi_rsp_t axi_rsp,
    input wire logic    rxd,
    input wire logic    irq,
    input wire logic    tx_halt
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence b_done;
        axi_rsp.bvalid && axi_req.bready;
    endsequence

    a_b_answer: assert property (wr_taken |=> !axi_rsp.awready ##1 axi_rsp.bvalid)
        else $error("write response not on time");
    a_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write response dropped early");
    a_b_release: assert property (b_done |=> !axi_rsp.bvalid && axi_rsp.awready && axi_rsp.wready)
        else $error("write channel not freed");
    a_r_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read data not on time");
    a_r_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped early");
    a_ready_blocked: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write accepted while response pending");
    a_halt_clear_write: assert property ($fell(tx_halt) |-> !axi_rsp.awready)
        else $error("transmit halt dropped without a write");
    a_irq_drop_write: assert property ($fell(irq) |-> !axi_rsp.awready)
        else $error("interrupt dropped without a write");
endmodule

bind sef_top sef_top_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .rxd(rxd), .irq(irq), .tx_halt(tx_halt));

// >>> verification/sef_tx_model.sv
// Behavioural remote transmitter that drives the serial receive line.
module sef_tx_model #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic aclk,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial rxd = 1'b1;

    // Start, eight data bits low first, two stop slots, then one idle slot so the receiver can finish.
    task automatic send(input logic [7:0] d, input logic stop1, input logic stop2);
        logic [11:0] f;
        f = {1'b1, stop2, stop1, d, 1'b0};
        for (int i = 0; i < 12; i++) begin
            @(posedge aclk);
            rxd <= f[i];
            repeat (BIT_CLKS - 1) @(posedge aclk);
        end
    endtask
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the receive-error flags block.
`include "sef_consts.svh"
module testbench
    import sef_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0]  ST = `SEF_OFS_STATUS;
    localparam logic [7:0]  HD = `SEF_OFS_HOLD;
    localparam logic [7:0]  CT = `SEF_OFS_CTRL;
    localparam logic [7:0]  IS = `SEF_OFS_IRQ_STAT;
    localparam logic [7:0]  IM = `SEF_OFS_IRQ_MASK;
    localparam logic [31:0] RXF = 32'h1 << `SEF_BIT_RXF;
    localparam logic [31:0] OVR = 32'h1 << `SEF_BIT_OVR;
    localparam logic [31:0] FRM = 32'h1 << `SEF_BIT_FRM;
    localparam logic [31:0] EN = 32'h1 << `SEF_CTL_RXEN;
    localparam logic [31:0] TWO = 32'h1 << `SEF_CTL_TWOSTOP;
    localparam logic [31:0] SYN = 32'h1 << `SEF_CTL_SYNC;

    logic         aclk;
    logic         aresetn;
    sef_axi_req_t req;
    sef_axi_rsp_t rsp;
    logic         rxd;
    logic         irq;
    logic         tx_halt;
    int           n_fail;
    int           checks;

    sef_top uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .rxd(rxd), .irq(irq),
        .tx_halt(tx_halt));
    sef_tx_model u_tx (.aclk(aclk), .rxd(rxd));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic summarize();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Every offset up to IM is expected to answer OKAY; only higher offsets expect SLVERR.
    function automatic logic [31:0] resp_of(input logic [7:0] a);
        return (a > IM) ? {30'h0, `SEF_RESP_SLVERR} : {30'h0, `SEF_RESP_OKAY};
    endfunction

    task automatic guard(inout int n);
        n++;
        if (n > 100) begin
            n_fail++;
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        req.awaddr <= {24'h0, a};
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        check("bresp", {30'h0, rsp.bresp}, resp_of(a));
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        int n;
        n = 0;
        @(posedge aclk);
        req.araddr <= {24'h0, a};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        check("rresp", {30'h0, rsp.rresp}, resp_of(a));
        check(what, rsp.rdata, exp);
    endtask

    task automatic t_reset();
        rchk(ST, 32'h0, "status");
        rchk(8'h20, 32'h0, "unmapped");
        wr(8'h20, 32'hff);
        wr(HD, 32'h5a);
        rchk(HD, 32'h0, "hold");
    endtask

    task automatic t_clean();
        wr(CT, EN);
        wr(IM, 32'h7);
        u_tx.send(8'ha5, 1'b1, 1'b1);
        rchk(ST, RXF, "status");
        rchk(HD, 32'ha5, "hold");
        check("irq", {31'h0, irq}, 32'h1);
        wr(IS, 32'h7);
        check("irq", {31'h0, irq}, 32'h0);
    endtask

    // Full flag is still set, so the next frame overruns; sync mode shows the transmit halt.
    task automatic t_overrun();
        wr(CT, EN | SYN);
        wr(IM, 32'h0);
        u_tx.send(8'h3c, 1'b1, 1'b1);
        wr(ST, 32'h0);
        rchk(ST, OVR, "status");
        rchk(HD, 32'ha5, "hold");
        check("tx_halt", {31'h0, tx_halt}, 32'h1);
        check("irq", {31'h0, irq}, 32'h0);
        wr(IM, 32'h7);
        check("irq", {31'h0, irq}, 32'h1);
        u_tx.send(8'h66, 1'b1, 1'b1);
        rchk(HD, 32'ha5, "hold");
        rchk(ST, OVR, "status");
        wr(CT, SYN);
        rchk(ST, OVR, "status");
        wr(ST, OVR);
        rchk(ST, OVR, "status");
        wr(ST, 32'h0);
        rchk(ST, 32'h0, "status");
        check("tx_halt", {31'h0, tx_halt}, 32'h0);
        wr(IS, 32'h7);
    endtask

    task automatic t_framing();
        wr(CT, EN);
        u_tx.send(8'h81, 1'b0, 1'b1);
        rchk(ST, FRM, "status");
        rchk(HD, 32'h81, "hold");
        u_tx.send(8'h7e, 1'b1, 1'b1);
        rchk(HD, 32'h81, "hold");
        wr(CT, SYN);
        check("tx_halt", {31'h0, tx_halt}, 32'h1);
        rchk(ST, FRM, "status");
        wr(ST, 32'h0);
        rchk(ST, 32'h0, "status");
    endtask

    task automatic t_twostop();
        wr(CT, EN | TWO);
        u_tx.send(8'h42, 1'b1, 1'b0);
        rchk(ST, RXF, "status");
        rchk(HD, 32'h42, "hold");
        wr(ST, 32'h0);
        u_tx.send(8'h18, 1'b0, 1'b1);
        rchk(ST, FRM, "status");
        rchk(HD, 32'h18, "hold");
    endtask

    initial begin
        req = '0;
        aresetn = 1'b0;
        n_fail = 0;
        checks = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_clean();
        t_overrun();
        t_framing();
        t_twostop();
        summarize();
    end
endmodule
